//--- dv/clock_partner.sv
// model of the alignment requester and the converter clock inputs
`timescale 1ns/1ps
`default_nettype none

module clock_partner (
	// input clock and divided clocks seen by the converters
	input  wire logic sys_clk,
	input  wire logic clk_out_a,
	input  wire logic clk_out_b,
	input  wire logic clk_out_c,
	// alignment request line
	output var logic  align_request_n
);
	initial align_request_n = 1'b1;

	task automatic set_low();
		@(negedge sys_clk);
		align_request_n = 1'b0;
	endtask

	// low for a full cycle at least
	task automatic set_high();
		@(negedge sys_clk);
		align_request_n = 1'b1;
	endtask

	function automatic logic pick(input int sel);
		return (sel == 0) ? clk_out_a : ((sel == 1) ? clk_out_b : clk_out_c);
	endfunction

	// high and total samples of one full period, bounded so a stuck output cannot hang
	task automatic measure(input int sel, output int hi, output int tot);
		int n;
		hi = 0;
		tot = 0;
		for (n = 0; n < 80 && pick(sel) !== 1'b0; n++) @(negedge sys_clk);
		for (n = 0; n < 80 && pick(sel) !== 1'b1; n++) @(negedge sys_clk);
		while (pick(sel) === 1'b1 && tot < 80) begin
			hi++;
			tot++;
			@(negedge sys_clk);
		end
		while (pick(sel) === 1'b0 && tot < 80) begin
			tot++;
			@(negedge sys_clk);
		end
	endtask
endmodule

`default_nettype wire

//--- dv/pin_configured_clock_divider_sync_test.sv
// self-checking bench for the pin-configured clock divider core
`timescale 1ns/1ps
`default_nettype none

module pin_configured_clock_divider_sync_test
	import clock_divider_pkg::*;
;
	logic            sys_clk;
	logic            reset_n;
	logic            align_request_n;
	level_type       pin [11];
	logic [10:0]     setup_pin_open;
	logic            clk_out_a;
	logic            clk_out_b;
	logic            clk_out_c;
	drive_type       drive_a;
	drive_type       drive_b;
	drive_type       drive_c;
	delay_scale_type delay_full_scale;
	logic [3:0]      fine_delay_step;
	logic            align_in_progress;
	int              mismatches;
	int              n_tests;
	int              hi;
	int              tot;
	int std_div [16] = '{1, 2, 3, 4, 5, 6, 8, 9, 10, 12, 15, 16, 18, 24, 30, 32};
	int odd_div [16] = '{7, 11, 13, 14, 17, 19, 20, 21, 22, 23, 25, 26, 27, 28, 29, 31};
	// {a, b, c} drive per usage*4 + standard
	logic [5:0] drv_tab [16] = '{6'h04, 6'h28, 6'h14, 6'h18, 6'h2A, 6'h15, 6'h16, 6'h29,
		6'h00, 6'h01, 6'h02, 6'h08, 6'h12, 6'h21, 6'h11, 6'h22};

	pin_configured_clock_divider_sync pin_configured_clock_divider_sync_inst (
		.sys_clk(sys_clk), .reset_n(reset_n), .align_request_n(align_request_n),
		.delay_scale_pin(pin[0]), .logic_standard_pin(pin[1]), .output_usage_pin(pin[2]),
		.fine_select_low_pin(pin[3]), .fine_select_high_pin(pin[4]),
		.pair_b_low_pin(pin[5]), .pair_b_high_pin(pin[6]), .pair_c_low_pin(pin[7]),
		.pair_c_high_pin(pin[8]), .pair_d_low_pin(pin[9]), .pair_d_high_pin(pin[10]),
		.setup_pin_open(setup_pin_open), .clk_out_a(clk_out_a), .clk_out_b(clk_out_b),
		.clk_out_c(clk_out_c), .drive_a(drive_a), .drive_b(drive_b), .drive_c(drive_c),
		.delay_full_scale(delay_full_scale), .fine_delay_step(fine_delay_step),
		.align_in_progress(align_in_progress));

	clock_partner clock_partner_inst (
		.sys_clk(sys_clk), .clk_out_a(clk_out_a), .clk_out_b(clk_out_b),
		.clk_out_c(clk_out_c), .align_request_n(align_request_n));

	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end

	task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
		n_tests++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask

	task automatic cfg(input logic [21:0] v);
		for (int i = 0; i < 11; i++) pin[i] = level_type'(v[2*i +: 2]);
	endtask

	task automatic close_out();
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// frozen levels during the request, then first-high sample of each output after release
	task automatic sync_check(input logic [2:0] frz, input int ea, eb, ec);
		int fa, fb, fc, fw;
		fa = 0;
		fb = 0;
		fc = 0;
		fw = 0;
		clock_partner_inst.set_low();
		repeat (3) @(negedge sys_clk);
		check({5'h00, clk_out_a, clk_out_b, clk_out_c}, {5'h00, frz}, "frozen");
		check({7'h00, align_in_progress}, 8'h01, "align busy");
		clock_partner_inst.set_high();
		for (int n = 1; n <= 40; n++) begin
			@(negedge sys_clk);
			if (fa == 0 && clk_out_a === 1'b1) fa = n;
			if (fb == 0 && clk_out_b === 1'b1) fb = n;
			if (fc == 0 && clk_out_c === 1'b1) fc = n;
			if (fw == 0 && align_in_progress === 1'b0) fw = n;
		end
		check(8'(fw), 8'h05, "align end");
		check(8'(fa), 8'(ea), "first edge a");
		check(8'(fb), 8'(eb), "first edge b");
		check(8'(fc), 8'(ec), "first edge c");
	endtask

	initial begin
		repeat (20000) @(posedge sys_clk);
		mismatches++;
		close_out();
	end

	initial begin
		int fa;
		mismatches = 0;
		n_tests = 0;
		reset_n = 1'b0;
		setup_pin_open = 11'h000;
		cfg(22'h040010);
		repeat (4) @(negedge sys_clk);
		check({clk_out_a, clk_out_b, clk_out_c, align_in_progress, drive_a, drive_b}, 8'h10,
			"reset");
		reset_n = 1'b1;
		fa = 0;
		for (int n = 1; n <= 20; n++) begin
			@(negedge sys_clk);
			if (fa == 0 && clk_out_a === 1'b1) fa = n;
		end
		check(8'(fa), 8'h06, "power-on edge");
		$display("test power_on done");
		for (int u = 0; u < 4; u++) begin
			for (int s = 0; s < 4; s++) begin
				pin[2] = level_type'(u);
				pin[1] = level_type'(s);
				@(negedge sys_clk);
				check({2'h0, drive_a, drive_b, drive_c}, {2'h0, drv_tab[u*4+s]}, "drive");
			end
		end
		// usage pin driven to zero but marked open, so it must read as one third
		pin[1] = LEVEL_ONE;
		pin[2] = LEVEL_ZERO;
		setup_pin_open = 11'h004;
		@(negedge sys_clk);
		check({2'h0, drive_a, drive_b, drive_c}, 8'h29, "open pin");
		setup_pin_open = 11'h000;
		$display("test drive done");
		for (int d = 0; d < 4; d++) begin
			pin[0] = level_type'(d);
			pin[3] = LEVEL_ONE;
			pin[4] = LEVEL_TWO_THIRDS;
			@(negedge sys_clk);
			check({6'h00, delay_full_scale}, 8'(d), "delay scale");
			check({4'h0, fine_delay_step}, (d == 0) ? 8'h00 : 8'h0B, "fine step");
		end
		$display("test delay done");
		cfg(22'h040D50);
		sync_check(3'b010, 7, 1, 12);
		cfg(22'h044944);
		sync_check(3'b000, 7, 9, 0);
		$display("test align done");
		for (int k = 1; k < 32; k++) begin
			cfg((k < 16) ? 22'h000010 : 22'h000024);
			pin[9] = level_type'(k % 4);
			pin[10] = level_type'((k % 16) / 4);
			clock_partner_inst.set_low();
			clock_partner_inst.set_high();
			// samples launched before the freeze reached the dividers may still pulse
			repeat (2) @(negedge sys_clk);
			clock_partner_inst.measure((k < 16) ? 0 : 2, hi, tot);
			if (k < 16) begin
				check(8'(tot), 8'(std_div[k]), "period a");
				check(8'(hi), 8'(std_div[k] / 2), "high time a");
			end else begin
				check(8'(tot), 8'(odd_div[k-16]), "period c");
				check(8'(hi), 8'(odd_div[k-16] / 2), "high time c");
			end
		end
		$display("test ratios done");
		close_out();
	end
endmodule

`default_nettype wire

//--- logic/clock_divider_params.svh
// timing counts, reset values and fixed codes of the clock divider core
`ifndef CLOCK_DIVIDER_PARAMS_SVH
`define CLOCK_DIVIDER_PARAMS_SVH

`define SYS_CLK_PERIOD_PS     25000
`define ALIGN_REQ_MIN_PS      5000
`define ALIGN_REQ_MIN_CYCLES  (((`ALIGN_REQ_MIN_PS + `SYS_CLK_PERIOD_PS - 1) / `SYS_CLK_PERIOD_PS) > 0 ? ((`ALIGN_REQ_MIN_PS + `SYS_CLK_PERIOD_PS - 1) / `SYS_CLK_PERIOD_PS) : 1)
`define ALIGN_WAIT_CYCLES     3'h4

`define RESET_WAIT_COUNT      3'h0
`define DIVIDE_BYPASS         6'h01
`define PHASE_NONE            4'h0
`define FINE_NONE             4'h0
`define COUNT_ZERO            6'h00

`define PIN_DELAY_SCALE       0
`define PIN_LOGIC_STANDARD    1
`define PIN_OUTPUT_USAGE      2
`define PIN_FINE_LOW          3
`define PIN_FINE_HIGH         4
`define PIN_PAIR_B_LOW        5
`define PIN_PAIR_B_HIGH       6
`define PIN_PAIR_C_LOW        7
`define PIN_PAIR_C_HIGH       8
`define PIN_PAIR_D_LOW        9
`define PIN_PAIR_D_HIGH       10

`endif

//--- logic/clock_divider_pkg.sv
// types shared by the clock divider core and its divider channels
`default_nettype none

package clock_divider_pkg;

	typedef enum logic [1:0] {
		LEVEL_ZERO       = 2'h0,
		LEVEL_THIRD      = 2'h1,
		LEVEL_TWO_THIRDS = 2'h2,
		LEVEL_ONE        = 2'h3
	} level_type;

	typedef enum logic [1:0] {
		DRIVE_OFF  = 2'h0,
		DRIVE_LVDS = 2'h1,
		DRIVE_CMOS = 2'h2
	} drive_type;

	typedef enum logic [1:0] {
		DELAY_BYPASS = 2'h0,
		DELAY_1P8_NS = 2'h1,
		DELAY_6P0_NS = 2'h2,
		DELAY_11P6_NS = 2'h3
	} delay_scale_type;

	typedef enum logic [1:0] {
		ALIGN_RUN  = 2'h0,
		ALIGN_HOLD = 2'h1,
		ALIGN_WAIT = 2'h2
	} align_state_type;

endpackage

`default_nettype wire

//--- logic/divider_channel.sv
// one output divider: free-running count, static freeze and phase-delayed restart
`timescale 1ns/1ps
`default_nettype none
`include "clock_divider_params.svh"

module divider_channel
	import clock_divider_pkg::*;
(
	// clock and reset
	input wire logic       sys_clk,
	input wire logic       reset_n,
	// settings and alignment from the core
	divider_link_if.divider link
);

	logic [5:0] cnt;
	logic [5:0] next_cnt;
	logic [3:0] wait_cnt;
	logic [3:0] next_wait_cnt;
	logic       waiting;
	logic       next_waiting;
	logic       next_level;

	always_comb begin
		next_cnt      = cnt;
		next_wait_cnt = wait_cnt;
		next_waiting  = waiting;
		next_level    = 1'b0;
		if (!link.enable) begin
			next_cnt     = `COUNT_ZERO;
			next_waiting = 1'b0;
		end else if (link.ratio == `DIVIDE_BYPASS) begin
			next_waiting = 1'b0;
			next_level   = 1'b1;
		end else if (link.hold) begin
			next_cnt     = link.ratio - 6'h01;
			next_waiting = 1'b0;
		end else if (link.start && link.phase == `PHASE_NONE) begin
			next_cnt   = `COUNT_ZERO;
			next_level = 1'b1;
		end else if (link.start || waiting) begin
			next_wait_cnt = link.start ? link.phase : wait_cnt - 4'h1;
			next_waiting  = 1'b1;
			if (!link.start && wait_cnt == 4'h1) begin
				next_waiting = 1'b0;
				next_cnt     = `COUNT_ZERO;
				next_level   = 1'b1;
			end
		end else begin
			// divide by ratio, high for half
			next_cnt   = (cnt >= link.ratio - 6'h01) ? `COUNT_ZERO : cnt + 6'h01;
			next_level = next_cnt < (link.ratio >> 1);
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt        <= `COUNT_ZERO;
			wait_cnt   <= `PHASE_NONE;
			waiting    <= 1'b0;
			link.level <= 1'b0;
		end else begin
			cnt        <= next_cnt;
			wait_cnt   <= next_wait_cnt;
			waiting    <= next_waiting;
			link.level <= next_level;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);

	a_bypass_follows: assert property (
		link.enable && link.ratio == `DIVIDE_BYPASS |=> link.level)
		else $error("bypassed output not following input clock");
	a_freeze_static: assert property (
		link.enable && link.ratio > `DIVIDE_BYPASS && link.hold
		|=> !link.level && cnt == $past(link.ratio) - 6'h01)
		else $error("held output not frozen");
	a_phase_two_wait: assert property (
		link.enable && link.ratio > `DIVIDE_BYPASS && link.start && !link.hold
		&& link.phase == 4'h2 ##1 (!link.hold && $stable(link.ratio))[*2]
		|-> !link.level ##1 link.level)
		else $error("phase offset two not honoured");
	a_disabled_quiet: assert property (
		!link.enable |=> !link.level && !waiting)
		else $error("disabled output is toggling");
	a_divide_period: assert property (
		link.enable && link.ratio == 6'h03 && !link.hold && !link.start && !waiting
		&& cnt == 6'h02 ##1 (link.ratio == 6'h03 && !link.hold && !link.start)[*3]
		|-> $past(link.level, 2) && !$past(link.level) && !link.level)
		else $error("divide by three waveform wrong");

endmodule

`default_nettype wire

//--- logic/divider_link_if.sv
// settings and alignment controls passed from the core to one divider channel
`timescale 1ns/1ps
`default_nettype none

interface divider_link_if;
	logic [5:0] ratio;
	logic [3:0] phase;
	logic       enable;
	logic       hold;
	logic       start;
	logic       level;

	modport core (output ratio, output phase, output enable, output hold, output start,
		input level);
	modport divider (input ratio, input phase, input enable, input hold, input start,
		output level);
endinterface

`default_nettype wire

//--- logic/pin_configured_clock_divider_sync.sv
// pin-configured three-output clock divider core with power-on and requested alignment
`timescale 1ns/1ps
`default_nettype none
`include "clock_divider_params.svh"

// Function
// - three dividers, ratios 1 to 32
// - third output delay, 16 fine steps
// - power-on alignment of non-bypassed dividers
// - request low freezes divided outputs static
// - four cycles after release, resume aligned
// - ratio one ignores alignment request
// - alignment keeps each programmed phase offset
// - request seen only if low at a clock edge, completes later
// - only enabled outputs are aligned
// - new request realigns at any time
// - four pin levels, open reads one-third
// - usage pin selects active outputs
// - delay pin picks full scale
// - fine pair: delay steps or phase
// - pair b: third divide or second phase
// - pair c: second divide or third phase
// - pair d: first divide or odd third
// - sixteen-entry drive standard mapping
// - phase word delays first edge
// - pair index and standard divide table
// - odd divide table for third output
module pin_configured_clock_divider_sync
	import clock_divider_pkg::*;
(
	// clock and power-on reset
	input  wire logic       sys_clk,
	input  wire logic       reset_n,
	// alignment request
	input  wire logic       align_request_n,
	// setup pins
	input  wire level_type  delay_scale_pin,
	input  wire level_type  logic_standard_pin,
	input  wire level_type  output_usage_pin,
	input  wire level_type  fine_select_low_pin,
	input  wire level_type  fine_select_high_pin,
	input  wire level_type  pair_b_low_pin,
	input  wire level_type  pair_b_high_pin,
	input  wire level_type  pair_c_low_pin,
	input  wire level_type  pair_c_high_pin,
	input  wire level_type  pair_d_low_pin,
	input  wire level_type  pair_d_high_pin,
	input  wire logic [10:0] setup_pin_open,
	// divided clocks
	output logic            clk_out_a,
	output logic            clk_out_b,
	output logic            clk_out_c,
	// output standard and delay settings
	output drive_type       drive_a,
	output drive_type       drive_b,
	output drive_type       drive_c,
	output delay_scale_type delay_full_scale,
	output logic [3:0]      fine_delay_step,
	// status
	output logic            align_in_progress
);

	////////////////////////////////////////////////////////////////////////////////
	function automatic level_type resolve(input level_type pin, input logic open);
		// open pin self-biases to one third
		return open ? LEVEL_THIRD : pin;
	endfunction

	function automatic logic [3:0] pair_index(input level_type low, input level_type high);
		return {high, low};
	endfunction

	function automatic logic [5:0] divide_standard(input logic [3:0] idx);
		logic [5:0] r;
		r = `DIVIDE_BYPASS;
		unique case (idx)
			4'h0: r = 6'h01;
			4'h1: r = 6'h02;
			4'h2: r = 6'h03;
			4'h3: r = 6'h04;
			4'h4: r = 6'h05;
			4'h5: r = 6'h06;
			4'h6: r = 6'h08;
			4'h7: r = 6'h09;
			4'h8: r = 6'h0A;
			4'h9: r = 6'h0C;
			4'hA: r = 6'h0F;
			4'hB: r = 6'h10;
			4'hC: r = 6'h12;
			4'hD: r = 6'h18;
			4'hE: r = 6'h1E;
			4'hF: r = 6'h20;
		endcase
		return r;
	endfunction

	function automatic logic [5:0] divide_odd(input logic [3:0] idx);
		logic [5:0] r;
		r = 6'h07;
		unique case (idx)
			4'h0: r = 6'h07;
			4'h1: r = 6'h0B;
			4'h2: r = 6'h0D;
			4'h3: r = 6'h0E;
			4'h4: r = 6'h11;
			4'h5: r = 6'h13;
			4'h6: r = 6'h14;
			4'h7: r = 6'h15;
			4'h8: r = 6'h16;
			4'h9: r = 6'h17;
			4'hA: r = 6'h19;
			4'hB: r = 6'h1A;
			4'hC: r = 6'h1B;
			4'hD: r = 6'h1C;
			4'hE: r = 6'h1D;
			4'hF: r = 6'h1F;
		endcase
		return r;
	endfunction

	// packed as {a, b, c}
	function automatic logic [5:0] drive_map(input level_type usage, input level_type std);
		logic [5:0] d;
		d = {DRIVE_OFF, DRIVE_OFF, DRIVE_OFF};
		unique case ({usage, std})
			4'h0: d = {DRIVE_OFF,  DRIVE_LVDS, DRIVE_OFF};
			4'h1: d = {DRIVE_CMOS, DRIVE_CMOS, DRIVE_OFF};
			4'h2: d = {DRIVE_LVDS, DRIVE_LVDS, DRIVE_OFF};
			4'h3: d = {DRIVE_LVDS, DRIVE_CMOS, DRIVE_OFF};
			4'h4: d = {DRIVE_CMOS, DRIVE_CMOS, DRIVE_CMOS};
			4'h5: d = {DRIVE_LVDS, DRIVE_LVDS, DRIVE_LVDS};
			4'h6: d = {DRIVE_LVDS, DRIVE_LVDS, DRIVE_CMOS};
			4'h7: d = {DRIVE_CMOS, DRIVE_CMOS, DRIVE_LVDS};
			4'h8: d = {DRIVE_OFF,  DRIVE_OFF,  DRIVE_OFF};
			4'h9: d = {DRIVE_OFF,  DRIVE_OFF,  DRIVE_LVDS};
			4'hA: d = {DRIVE_OFF,  DRIVE_OFF,  DRIVE_CMOS};
			4'hB: d = {DRIVE_OFF,  DRIVE_CMOS, DRIVE_OFF};
			4'hC: d = {DRIVE_LVDS, DRIVE_OFF,  DRIVE_CMOS};
			4'hD: d = {DRIVE_CMOS, DRIVE_OFF,  DRIVE_LVDS};
			4'hE: d = {DRIVE_LVDS, DRIVE_OFF,  DRIVE_LVDS};
			4'hF: d = {DRIVE_CMOS, DRIVE_OFF,  DRIVE_CMOS};
		endcase
		return d;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	divider_link_if link_a ();
	divider_link_if link_b ();
	divider_link_if link_c ();

	level_type       lv_delay;
	level_type       lv_usage;
	logic [3:0]      fine_idx;
	logic [3:0]      pair_b_idx;
	logic [3:0]      pair_c_idx;
	logic [3:0]      pair_d_idx;
	logic [5:0]      drives;
	logic [5:0]      next_ratio_a;
	logic [5:0]      next_ratio_b;
	logic [5:0]      next_ratio_c;
	logic [3:0]      next_phase_b;
	logic [3:0]      next_phase_c;
	logic [3:0]      next_fine;
	delay_scale_type next_scale;

	// decoded every cycle, no realign on change
	always_comb begin
		lv_delay   = resolve(delay_scale_pin, setup_pin_open[`PIN_DELAY_SCALE]);
		lv_usage   = resolve(output_usage_pin, setup_pin_open[`PIN_OUTPUT_USAGE]);
		fine_idx   = pair_index(resolve(fine_select_low_pin, setup_pin_open[`PIN_FINE_LOW]),
			resolve(fine_select_high_pin, setup_pin_open[`PIN_FINE_HIGH]));
		pair_b_idx = pair_index(resolve(pair_b_low_pin, setup_pin_open[`PIN_PAIR_B_LOW]),
			resolve(pair_b_high_pin, setup_pin_open[`PIN_PAIR_B_HIGH]));
		pair_c_idx = pair_index(resolve(pair_c_low_pin, setup_pin_open[`PIN_PAIR_C_LOW]),
			resolve(pair_c_high_pin, setup_pin_open[`PIN_PAIR_C_HIGH]));
		pair_d_idx = pair_index(resolve(pair_d_low_pin, setup_pin_open[`PIN_PAIR_D_LOW]),
			resolve(pair_d_high_pin, setup_pin_open[`PIN_PAIR_D_HIGH]));
		// usage with standard gives per-output drive
		drives     = drive_map(lv_usage,
			resolve(logic_standard_pin, setup_pin_open[`PIN_LOGIC_STANDARD]));
		next_scale = delay_scale_type'(lv_delay);
		next_fine  = `FINE_NONE;
		next_phase_b = `PHASE_NONE;
		next_phase_c = `PHASE_NONE;
		next_ratio_c = `DIVIDE_BYPASS;
		// fine step as n/16 of full scale
		// fine pair: delay step or third phase
		if (lv_delay != LEVEL_ZERO) begin
			next_fine = fine_idx;
		end else begin
			next_phase_c = fine_idx;
		end
		if (lv_usage != LEVEL_ZERO) begin
			next_ratio_c = divide_standard(pair_b_idx);
		end else begin
			next_phase_b = pair_b_idx;
		end
		// pair c meaning follows usage and delay
		next_ratio_b = divide_standard(pair_c_idx);
		if (lv_usage == LEVEL_ONE) begin
			next_ratio_b = `DIVIDE_BYPASS;
			if (lv_delay != LEVEL_ZERO) begin
				next_phase_c = pair_c_idx;
			end
		end
		// pair d: first divide or odd third divide
		next_ratio_a = divide_standard(pair_d_idx);
		if (lv_usage == LEVEL_TWO_THIRDS) begin
			next_ratio_a = `DIVIDE_BYPASS;
			next_ratio_c = divide_odd(pair_d_idx);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	align_state_type state;
	align_state_type next_state;
	logic [2:0]      wait_cnt;
	logic [2:0]      next_wait_cnt;
	logic            hold;
	logic            next_hold;
	logic            start;
	logic            next_start;

	// a single sampled low is enough: the 5 ns minimum is shorter than one period,
	// so a narrower pulse that falls between edges is not seen
	always_comb begin
		next_state    = state;
		next_wait_cnt = wait_cnt;
		next_start    = 1'b0;
		unique case (state)
			ALIGN_RUN: begin
				if (!align_request_n) begin
					next_state = ALIGN_HOLD;
				end
			end
			ALIGN_HOLD: begin
				// line must return high to leave hold
				if (align_request_n) begin
					next_state    = ALIGN_WAIT;
					next_wait_cnt = `RESET_WAIT_COUNT;
				end
			end
			ALIGN_WAIT: begin
				// wait counts only arriving clock edges
				if (!align_request_n) begin
					next_state = ALIGN_HOLD;
				end else if (wait_cnt == `ALIGN_WAIT_CYCLES - 3'h1) begin
					next_state = ALIGN_RUN;
					next_start = 1'b1;
				end else begin
					next_wait_cnt = wait_cnt + 3'h1;
				end
			end
		endcase
		next_hold = next_state != ALIGN_RUN;
	end

	// reset enters wait, giving power-on alignment
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			state             <= ALIGN_WAIT;
			wait_cnt          <= `RESET_WAIT_COUNT;
			hold              <= 1'b1;
			start             <= 1'b0;
			align_in_progress <= 1'b1;
		end else begin
			state             <= next_state;
			wait_cnt          <= next_wait_cnt;
			hold              <= next_hold;
			start             <= next_start;
			align_in_progress <= next_hold;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// shared start, channels b and c add own phase, a has none
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			link_a.ratio     <= `DIVIDE_BYPASS;
			link_b.ratio     <= `DIVIDE_BYPASS;
			link_c.ratio     <= `DIVIDE_BYPASS;
			link_a.phase     <= `PHASE_NONE;
			link_b.phase     <= `PHASE_NONE;
			link_c.phase     <= `PHASE_NONE;
			link_a.enable    <= 1'b0;
			link_b.enable    <= 1'b0;
			link_c.enable    <= 1'b0;
			drive_a          <= DRIVE_OFF;
			drive_b          <= DRIVE_OFF;
			drive_c          <= DRIVE_OFF;
			delay_full_scale <= DELAY_BYPASS;
			fine_delay_step  <= `FINE_NONE;
			clk_out_a        <= 1'b0;
			clk_out_b        <= 1'b0;
			clk_out_c        <= 1'b0;
		end else begin
			link_a.ratio     <= next_ratio_a;
			link_b.ratio     <= next_ratio_b;
			link_c.ratio     <= next_ratio_c;
			link_a.phase     <= `PHASE_NONE;
			link_b.phase     <= next_phase_b;
			link_c.phase     <= next_phase_c;
			link_a.enable    <= drive_type'(drives[5:4]) != DRIVE_OFF;
			link_b.enable    <= drive_type'(drives[3:2]) != DRIVE_OFF;
			link_c.enable    <= drive_type'(drives[1:0]) != DRIVE_OFF;
			drive_a          <= drive_type'(drives[5:4]);
			drive_b          <= drive_type'(drives[3:2]);
			drive_c          <= drive_type'(drives[1:0]);
			delay_full_scale <= next_scale;
			fine_delay_step  <= next_fine;
			clk_out_a        <= link_a.level;
			clk_out_b        <= link_b.level;
			clk_out_c        <= link_c.level;
		end
	end

	assign link_a.hold  = hold;
	assign link_b.hold  = hold;
	assign link_c.hold  = hold;
	assign link_a.start = start;
	assign link_b.start = start;
	assign link_c.start = start;

	divider_channel u_div_a (.sys_clk(sys_clk), .reset_n(reset_n), .link(link_a.divider));
	divider_channel u_div_b (.sys_clk(sys_clk), .reset_n(reset_n), .link(link_b.divider));
	divider_channel u_div_c (.sys_clk(sys_clk), .reset_n(reset_n), .link(link_c.divider));

	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);

	a_request_holds: assert property (
		!align_request_n |=> hold && !start ##1 align_in_progress)
		else $error("request low did not hold dividers");
	a_release_four_cycles: assert property (
		state == ALIGN_HOLD && align_request_n ##1 align_request_n[*4] |=> start && !hold)
		else $error("start not issued four cycles after release");
	a_usage_off_third: assert property (
		lv_usage == LEVEL_ZERO |=> drive_c == DRIVE_OFF && !link_c.enable)
		else $error("third output not off for usage level zero");
	a_odd_ratio_pick: assert property (
		lv_usage == LEVEL_TWO_THIRDS && pair_d_idx == 4'h0 |=> link_c.ratio == 6'h07)
		else $error("odd divide table not applied");
	a_standard_top_ratio: assert property (
		lv_usage != LEVEL_TWO_THIRDS && pair_d_idx == 4'hF |=> link_a.ratio == 6'h20)
		else $error("standard divide table top entry wrong");
	a_fine_step_route: assert property (
		lv_delay != LEVEL_ZERO |=> fine_delay_step == $past(fine_idx))
		else $error("fine delay step not routed");
	a_open_pin_third: assert property (
		setup_pin_open[`PIN_OUTPUT_USAGE] |-> lv_usage == LEVEL_THIRD)
		else $error("open usage pin not read as one third");

endmodule

`default_nettype wire
